// ==== logic/sctl_pkg.sv ====
// constants and types shared by the system configuration register bank
package sctl_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFS_FILL       = 8'h44;
	localparam logic [7:0]  OFS_SYSCFG     = 8'h48;
	localparam logic [7:0]  OFS_SCRATCH    = 8'h4c;
	localparam logic [7:0]  OFS_FADDR      = 8'h50;
	localparam logic [7:0]  OFS_FDATA      = 8'h54;
	localparam logic [7:0]  OFS_EADDR      = 8'h58;
	localparam logic [7:0]  OFS_EDATA      = 8'h5c;

	// ----------------------------------------------------------------
	// field positions and widths
	// ----------------------------------------------------------------
	localparam int          FILL_LSB       = 16;
	localparam int          FILL_W         = 9;
	localparam int          WTHR_LSB       = 8;
	localparam int          RTHR_LSB       = 0;
	localparam int          THR_W          = 6;
	localparam int          IRQ1_BIT       = 23;
	localparam int          IRQ0_BIT       = 22;
	localparam int          CLKSEL_LSB     = 20;
	localparam int          STRAP_BIT      = 16;
	localparam int          IF0_RST_BIT    = 7;
	localparam int          IF1_RST_BIT    = 6;
	localparam int          BUF0_RST_BIT   = 5;
	localparam int          BUF1_RST_BIT   = 4;
	localparam int          ARB_RST_BIT    = 1;
	localparam int          BM_RST_BIT     = 0;
	localparam int          MEM_ERR_BIT    = 28;
	localparam int          MEM_DONE_BIT   = 27;
	localparam int          MEM_IND_BIT    = 26;
	localparam int          MEM_START_BIT  = 25;
	localparam int          MEM_TYPE_BIT   = 24;
	localparam int          FLASH_AW       = 19;
	localparam int          PROM_AW        = 16;
	localparam int          MDATA_W        = 8;

	// ----------------------------------------------------------------
	// writable bit masks and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] FILL_WMASK     = 32'h00003f3f;
	localparam logic [31:0] SYS_WMASK      = 32'h00f000f3;
	localparam logic [31:0] FADDR_WMASK    = 32'h0107ffff;
	localparam logic [31:0] EADDR_WMASK    = 32'h0100ffff;
	localparam logic [31:0] DATA_WMASK     = 32'h000000ff;
	localparam logic [31:0] RST_REG        = 32'h00000000;
	localparam logic [7:0]  RST_MDATA      = 8'h00;
	localparam logic        IND_VALUE      = 1'b0;

	// ----------------------------------------------------------------
	// misc constants
	// ----------------------------------------------------------------
	localparam logic [8:0]  BUF_BYTES      = 9'h100;
	localparam logic [1:0]  NAK_LAST       = 2'h2;
	localparam logic [1:0]  CLKSEL_OFF     = 2'h3;
	localparam logic        HRESP_OKAY     = 1'b0;

	typedef enum logic [2:0] {
		ARB_IDLE = 3'b001,
		ARB_CH0  = 3'b010,
		ARB_CH1  = 3'b100
	} sctl_arb_type;

	typedef enum logic [2:0] {
		SEQ_INIT = 3'b001,
		SEQ_IDLE = 3'b010,
		SEQ_RUN  = 3'b100
	} sctl_seq_type;
endpackage : sctl_pkg

// ==== logic/sctl_mem_seq.sv ====
// access sequencer for one external boot or configuration memory
`timescale 1ns/1ps
module sctl_mem_seq #(
	parameter int AW     = 19,
	parameter bit NAK_EN = 1'b0
) (
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          start,
	input  wire logic          rd,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic               idle,
	output logic               busy,
	output logic               init_done,
	output logic               done,
	output logic               rd_valid,
	output logic [7:0]         rdata,
	output logic               err,
	output logic               mem_req,
	output logic               mem_rd,
	output logic [AW-1:0]      mem_addr,
	output logic [7:0]         mem_wdata,
	input  wire logic          mem_ack,
	input  wire logic          mem_nak,
	input  wire logic [7:0]    mem_rdata
);
	import sctl_pkg::*;

	sctl_seq_type state_q;
	logic [1:0]   nak_q;
	logic         nak_hit;

	assign nak_hit = NAK_EN & mem_nak & ~mem_ack;
	assign idle    = (state_q == SEQ_IDLE);
	assign busy    = (state_q == SEQ_RUN);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q   <= SEQ_INIT;
			mem_req   <= 1'b1;
			mem_rd    <= 1'b1;
			mem_addr  <= '0;
			mem_wdata <= RST_MDATA;
			nak_q     <= 2'h0;
			init_done <= 1'b0;
			done      <= 1'b0;
			rd_valid  <= 1'b0;
			rdata     <= RST_MDATA;
			err       <= 1'b0;
		end else begin
			done     <= 1'b0;
			rd_valid <= 1'b0;
			err      <= 1'b0;
			case (state_q)
				SEQ_IDLE: begin
					if (start) begin
						state_q   <= SEQ_RUN;
						mem_req   <= 1'b1;
						mem_rd    <= rd;
						mem_addr  <= addr;
						mem_wdata <= wdata;
						nak_q     <= 2'h0;
					end
				end
				SEQ_INIT, SEQ_RUN: begin
					if (mem_ack || (nak_hit && nak_q == NAK_LAST)) begin
						state_q   <= SEQ_IDLE;
						mem_req   <= 1'b0;
						init_done <= 1'b1;
						done      <= (state_q == SEQ_RUN);
						rd_valid  <= (state_q == SEQ_RUN) & mem_rd & mem_ack;
						err       <= ~mem_ack;
						if (mem_ack) begin
							rdata <= mem_rdata;
						end
					end else if (nak_hit) begin
						nak_q <= nak_q + 2'h1;
					end
				end
				default: begin
					state_q <= SEQ_IDLE;
					mem_req <= 1'b0;
				end
			endcase
		end
	end
endmodule : sctl_mem_seq

// ==== logic/sctl_regs.sv ====
// system configuration register bank behind an ahb-lite slave port
// Operation
// - channel-1 fill count field reads buffer byte count, 0x100 meaning full.
// - write toward memory: priority 1 when buffered dwords exceed write threshold.
// - read from memory: priority 1 when free dwords exceed read threshold.
// - simultaneous requests go to higher priority; ties go to last owner.
// - owner yields only to a strictly higher-priority requester.
// - each channel interrupt mask bit blocks that channel from the interrupt.
// - two-bit drive clock select: 100, 133, twice bus clock, stopped.
// - strap status bit follows the base-five decode strap pin.
// - channel interface reset bits hold interface logic reset while set.
// - channel buffer reset bits reset buffer pointers and fill count.
// - arbiter reset and bus-master reset bits reset those machines.
// - scratch word is read/write and never cleared by any reset.
// - after reset each memory interface initialises then sets init-done.
// - start bit begins an access; hardware clears it when finished.
// - access type one means read, zero means write.
// - flash address is nineteen bits; bits 23 to 19 read zero.
// - flash data low byte carries write byte and returns read byte.
// - three naks set the prom error bit; writing one clears it.
// - prom address is sixteen bits; bits 23 to 16 read zero.
// - bit 26 of both command registers is indeterminate; other reserved zero.
// - prom data low byte carries write byte and returns read byte.
`timescale 1ns/1ps
module sctl_regs (
	input  wire logic                            mclk,
	input  wire logic                            rst,
	input  wire logic                            hsel,
	input  wire logic [31:0]                     haddr,
	input  wire logic [1:0]                      htrans,
	input  wire logic                            hwrite,
	input  wire logic [2:0]                      hsize,
	input  wire logic [31:0]                     hwdata,
	input  wire logic                            hready,
	output logic                                 hreadyout,
	output logic                                 hresp,
	output logic [31:0]                          hrdata,
	input  wire logic [sctl_pkg::FILL_W-1:0]     ch1_buffer_fill_count,
	input  wire logic                            ch1_dir_to_mem,
	input  wire logic                            ch0_priority,
	output logic                                 ch1_priority,
	input  wire logic                            ch0_dma_req,
	input  wire logic                            ch1_dma_req,
	output logic                                 ch0_dma_grant,
	output logic                                 ch1_dma_grant,
	output logic                                 ch0_yield,
	output logic                                 ch1_yield,
	input  wire logic                            ch0_irq,
	input  wire logic                            ch1_irq,
	output logic                                 pci_irq,
	output logic [1:0]                           drive_clock_select,
	output logic                                 drive_clock_stop,
	input  wire logic                            base5_decode_strap,
	output logic                                 ch0_interface_reset,
	output logic                                 ch1_interface_reset,
	output logic                                 ch0_buffer_reset,
	output logic                                 ch1_buffer_reset,
	output logic                                 arbiter_reset,
	output logic                                 bus_master_reset,
	output logic                                 fl_req,
	output logic                                 fl_rd,
	output logic [sctl_pkg::FLASH_AW-1:0]        fl_addr,
	output logic [7:0]                           fl_wdata,
	input  wire logic                            fl_ack,
	input  wire logic [7:0]                      fl_rdata,
	output logic                                 ep_req,
	output logic                                 ep_rd,
	output logic [sctl_pkg::PROM_AW-1:0]         ep_addr,
	output logic [7:0]                           ep_wdata,
	input  wire logic                            ep_ack,
	input  wire logic                            ep_nak,
	input  wire logic [7:0]                      ep_rdata
);
	import sctl_pkg::*;

	logic [7:0]   a_q;
	logic         wr_q;
	logic         rdw_q;
	logic         acc;
	logic [31:0]  fcfg_q;
	logic [31:0]  sys_q;
	logic [31:0]  scratch_q;
	logic [31:0]  fadr_q;
	logic [31:0]  fdat_q;
	logic [31:0]  eadr_q;
	logic [31:0]  edat_q;
	logic         ep_err_q;
	logic         strap_s1_q;
	logic         strap_s2_q;
	logic [31:0]  rd_d;
	logic [6:0]   fill_dw;
	logic [8:0]   free_b;
	logic [6:0]   free_dw;
	logic         pick1;
	sctl_arb_type arb_q;
	logic         last1_q;
	logic         arb_rst;
	logic         fl_start;
	logic         ep_start;
	logic         fl_idle;
	logic         fl_busy;
	logic         fl_init;
	logic         fl_rdv;
	logic [7:0]   fl_byte;
	logic         ep_idle;
	logic         ep_busy;
	logic         ep_init;
	logic         ep_rdv;
	logic [7:0]   ep_byte;
	logic         ep_err_set;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a[7:2] == ofs[7:2]);
	endfunction : hit

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	assign acc       = hsel & htrans[1] & hready;
	assign hreadyout = ~rdw_q;
	assign hresp     = HRESP_OKAY;

	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_q  <= 1'b0;
			rdw_q <= 1'b0;
			a_q   <= 8'h00;
		end else begin
			wr_q  <= acc & hwrite;
			rdw_q <= acc & ~hwrite;
			if (acc) begin
				a_q <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			hrdata <= RST_REG;
		end else if (rdw_q) begin
			hrdata <= rd_d;
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_d = RST_REG;
		if (hit(a_q, OFS_FILL)) begin
			rd_d = fcfg_q;
			rd_d[FILL_LSB +: FILL_W] = ch1_buffer_fill_count;
		end else if (hit(a_q, OFS_SYSCFG)) begin
			rd_d = sys_q;
			rd_d[STRAP_BIT] = strap_s2_q;
		end else if (hit(a_q, OFS_SCRATCH)) begin
			rd_d = scratch_q;
		end else if (hit(a_q, OFS_FADDR)) begin
			rd_d = fadr_q;
			rd_d[MEM_DONE_BIT] = fl_init;
			rd_d[MEM_IND_BIT] = IND_VALUE;
			rd_d[MEM_START_BIT] = fl_busy;
		end else if (hit(a_q, OFS_FDATA)) begin
			rd_d = fdat_q;
		end else if (hit(a_q, OFS_EADDR)) begin
			rd_d = eadr_q;
			rd_d[MEM_ERR_BIT] = ep_err_q | ep_err_set;
			rd_d[MEM_DONE_BIT] = ep_init;
			rd_d[MEM_IND_BIT] = IND_VALUE;
			rd_d[MEM_START_BIT] = ep_busy;
		end else if (hit(a_q, OFS_EDATA)) begin
			rd_d = edat_q;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			fcfg_q <= RST_REG;
			sys_q  <= RST_REG;
			fadr_q <= RST_REG;
			eadr_q <= RST_REG;
		end else if (wr_q) begin
			if (hit(a_q, OFS_FILL)) begin
				fcfg_q <= hwdata & FILL_WMASK;
			end
			if (hit(a_q, OFS_SYSCFG)) begin
				sys_q <= hwdata & SYS_WMASK;
			end
			if (hit(a_q, OFS_FADDR)) begin
				fadr_q <= hwdata & FADDR_WMASK;
			end
			if (hit(a_q, OFS_EADDR)) begin
				eadr_q <= hwdata & EADDR_WMASK;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (wr_q && hit(a_q, OFS_SCRATCH)) begin
			scratch_q <= hwdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			fdat_q <= RST_REG;
		end else if (fl_rdv) begin
			fdat_q <= {24'h000000, fl_byte};
		end else if (wr_q && hit(a_q, OFS_FDATA)) begin
			fdat_q <= hwdata & DATA_WMASK;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			edat_q <= RST_REG;
		end else if (ep_rdv) begin
			edat_q <= {24'h000000, ep_byte};
		end else if (wr_q && hit(a_q, OFS_EDATA)) begin
			edat_q <= hwdata & DATA_WMASK;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ep_err_q <= 1'b0;
		end else if (ep_err_set) begin
			ep_err_q <= 1'b1;
		end else if (wr_q && hit(a_q, OFS_EADDR) && hwdata[MEM_ERR_BIT]) begin
			ep_err_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// strap synchroniser and system controls
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
		end else begin
			strap_s1_q <= base5_decode_strap;
			strap_s2_q <= strap_s1_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pci_irq <= 1'b0;
		end else begin
			pci_irq <= (ch0_irq & ~sys_q[IRQ0_BIT]) | (ch1_irq & ~sys_q[IRQ1_BIT]);
		end
	end

	assign drive_clock_select  = sys_q[CLKSEL_LSB +: 2];
	assign drive_clock_stop    = (sys_q[CLKSEL_LSB +: 2] == CLKSEL_OFF);
	assign ch0_interface_reset = sys_q[IF0_RST_BIT];
	assign ch1_interface_reset = sys_q[IF1_RST_BIT];
	assign ch0_buffer_reset    = sys_q[BUF0_RST_BIT];
	assign ch1_buffer_reset    = sys_q[BUF1_RST_BIT];
	assign arbiter_reset       = sys_q[ARB_RST_BIT];
	assign bus_master_reset    = sys_q[BM_RST_BIT];

	// ----------------------------------------------------------------
	// channel-1 priority and dma arbiter
	// ----------------------------------------------------------------
	assign fill_dw = ch1_buffer_fill_count[8:2];
	assign free_b  = BUF_BYTES - ch1_buffer_fill_count;
	assign free_dw = free_b[8:2];

	always_ff @(posedge mclk) begin
		if (rst) begin
			ch1_priority <= 1'b0;
		end else if (ch1_dir_to_mem) begin
			ch1_priority <= (fill_dw > {1'b0, fcfg_q[WTHR_LSB +: THR_W]});
		end else begin
			ch1_priority <= (free_dw > {1'b0, fcfg_q[RTHR_LSB +: THR_W]});
		end
	end

	assign arb_rst = rst | sys_q[ARB_RST_BIT];
	// higher priority, tie to last owner
	assign pick1   = (ch1_priority & ~ch0_priority)
		| ((ch1_priority == ch0_priority) & last1_q);

	always_ff @(posedge mclk) begin
		if (arb_rst) begin
			arb_q   <= ARB_IDLE;
			last1_q <= 1'b0;
		end else begin
			case (arb_q)
				ARB_IDLE: begin
					if (ch0_dma_req && ch1_dma_req) begin
						arb_q <= pick1 ? ARB_CH1 : ARB_CH0;
					end else if (ch0_dma_req) begin
						arb_q <= ARB_CH0;
					end else if (ch1_dma_req) begin
						arb_q <= ARB_CH1;
					end
				end
				ARB_CH0: begin
					if (!ch0_dma_req) begin
						arb_q   <= ARB_IDLE;
						last1_q <= 1'b0;
					end
				end
				ARB_CH1: begin
					if (!ch1_dma_req) begin
						arb_q   <= ARB_IDLE;
						last1_q <= 1'b1;
					end
				end
				default: begin
					arb_q <= ARB_IDLE;
				end
			endcase
		end
	end

	assign ch0_dma_grant = (arb_q == ARB_CH0);
	assign ch1_dma_grant = (arb_q == ARB_CH1);
	assign ch0_yield = ch0_dma_grant & ch1_dma_req & ch1_priority & ~ch0_priority;
	assign ch1_yield = ch1_dma_grant & ch0_dma_req & ch0_priority & ~ch1_priority;

	// ----------------------------------------------------------------
	// flash and prom sequencers
	// ----------------------------------------------------------------
	// start an access
	assign fl_start = wr_q & hit(a_q, OFS_FADDR) & hwdata[MEM_START_BIT] & fl_idle;
	assign ep_start = wr_q & hit(a_q, OFS_EADDR) & hwdata[MEM_START_BIT] & ep_idle;

	sctl_mem_seq #(.AW(FLASH_AW), .NAK_EN(1'b0)) u_flash (
		.mclk      (mclk),
		.rst       (rst),
		.start     (fl_start),
		.rd        (hwdata[MEM_TYPE_BIT]),
		.addr      (hwdata[FLASH_AW-1:0]),
		.wdata     (fdat_q[MDATA_W-1:0]),
		.idle      (fl_idle),
		.busy      (fl_busy),
		.init_done (fl_init),
		.done      (),
		.rd_valid  (fl_rdv),
		.rdata     (fl_byte),
		.err       (),
		.mem_req   (fl_req),
		.mem_rd    (fl_rd),
		.mem_addr  (fl_addr),
		.mem_wdata (fl_wdata),
		.mem_ack   (fl_ack),
		.mem_nak   (1'b0),
		.mem_rdata (fl_rdata)
	);

	sctl_mem_seq #(.AW(PROM_AW), .NAK_EN(1'b1)) u_prom (
		.mclk      (mclk),
		.rst       (rst),
		.start     (ep_start),
		.rd        (hwdata[MEM_TYPE_BIT]),
		.addr      (hwdata[PROM_AW-1:0]),
		.wdata     (edat_q[MDATA_W-1:0]),
		.idle      (ep_idle),
		.busy      (ep_busy),
		.init_done (ep_init),
		.done      (),
		.rd_valid  (ep_rdv),
		.rdata     (ep_byte),
		.err       (ep_err_set),
		.mem_req   (ep_req),
		.mem_rd    (ep_rd),
		.mem_addr  (ep_addr),
		.mem_wdata (ep_wdata),
		.mem_ack   (ep_ack),
		.mem_nak   (ep_nak),
		.mem_rdata (ep_rdata)
	);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_fl_go;
		fl_start;
	endsequence
	sequence s_fl_restart;
		wr_q && hit(a_q, OFS_FADDR) && hwdata[MEM_START_BIT] && fl_busy;
	endsequence
	sequence s_sys_wr;
		wr_q && hit(a_q, OFS_SYSCFG);
	endsequence

	property p_wr_pri;
		(ch1_dir_to_mem && fill_dw > {1'b0, fcfg_q[WTHR_LSB +: THR_W]}) |=> ch1_priority;
	endproperty
	a_wr_pri: assert property (p_wr_pri) else $error("write priority not raised");

	property p_rd_pri;
		(!ch1_dir_to_mem && free_dw <= {1'b0, fcfg_q[RTHR_LSB +: THR_W]}) |=> !ch1_priority;
	endproperty
	a_rd_pri: assert property (p_rd_pri) else $error("read priority raised early");

	property p_tie;
		(arb_q == ARB_IDLE && ch0_dma_req && ch1_dma_req && ch1_priority == ch0_priority
			&& last1_q && !arbiter_reset) |=> ch1_dma_grant;
	endproperty
	a_tie: assert property (p_tie) else $error("tie not given to last owner");

	property p_keep;
		(ch0_dma_grant && ch0_dma_req && !ch1_priority && !arbiter_reset)
			|-> !ch0_yield ##1 ch0_dma_grant;
	endproperty
	a_keep: assert property (p_keep) else $error("owner lost bus to equal priority");

	property p_mask;
		(sys_q[IRQ0_BIT] && sys_q[IRQ1_BIT]) |=> !pci_irq;
	endproperty
	a_mask: assert property (p_mask) else $error("masked interrupt reached output");

	property p_ifrst;
		(s_sys_wr and hwdata[IF0_RST_BIT]) |=> ch0_interface_reset;
	endproperty
	a_ifrst: assert property (p_ifrst) else $error("interface reset not applied");

	property p_start;
		s_fl_go |=> (fl_busy && fl_req && fl_addr == $past(hwdata[FLASH_AW-1:0]));
	endproperty
	a_start: assert property (p_start) else $error("flash access did not start");

	property p_err;
		ep_err_set |=> ep_err_q;
	endproperty
	a_err: assert property (p_err) else $error("prom error not latched");

	property p_restart;
		s_fl_restart |=> $stable(fl_addr);
	endproperty
	a_restart: assert property (p_restart) else $error("running access disturbed");
endmodule : sctl_regs

// ==== tb/sctl_mem_model.sv ====
// memory-side responders for the flash and prom sequencers
`timescale 1ns/1ps
module sctl_mem_model (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [2:0]  delay,
	input  wire logic [1:0]  naks,
	input  wire logic        fl_req,
	input  wire logic [18:0] fl_addr,
	output logic             fl_ack,
	output logic [7:0]       fl_rdata,
	input  wire logic        ep_req,
	input  wire logic [15:0] ep_addr,
	output logic             ep_ack,
	output logic             ep_nak,
	output logic [7:0]       ep_rdata
);
	logic [2:0] fc, ec;
	logic [1:0] left;
	logic       fgo, ego;
	assign fgo = fl_req && !fl_ack && !rst;
	assign ego = ep_req && !ep_ack && !ep_nak && !rst;
	// flash: one ack after the delay, data toggles outside it
	always_ff @(posedge mclk) begin
		fc <= fgo ? fc + 3'h1 : 3'h0;
		fl_ack <= fgo && fc == delay;
		fl_rdata <= (fgo && fc == delay) ? fl_addr[7:0] ^ 8'h5a : ~fl_rdata;
	end
	always_ff @(posedge mclk) begin
		ec <= ego ? ec + 3'h1 : 3'h0;
		left <= (rst || !ep_req) ? naks : left - {1'b0, ego && ec == delay && left != 2'h0};
		ep_nak <= ego && ec == delay && left != 2'h0;
		ep_ack <= ego && ec == delay && left == 2'h0;
		ep_rdata <= (ego && ec == delay) ? ep_addr[7:0] ^ 8'hc3 : ~ep_rdata;
	end
endmodule : sctl_mem_model

// ==== tb/sctl_regs_tb.sv ====
// self-checking bench for the system configuration register bank
`timescale 1ns/1ps
module sctl_regs_tb;
	import sctl_pkg::*;
	logic        mclk, rst, hsel, hwrite, hready, hreadyout, hresp, pci_irq, fl_req, fl_rd;
	logic        ch1_dir_to_mem, ch0_priority, ch1_priority, ch0_dma_req, ch1_dma_req;
	logic        ch0_dma_grant, ch1_dma_grant, ch0_yield, ch1_yield, ch0_irq, ch1_irq;
	logic        drive_clock_stop, base5_decode_strap, ch0_interface_reset, ch1_interface_reset;
	logic        ch0_buffer_reset, ch1_buffer_reset, arbiter_reset, bus_master_reset;
	logic        fl_ack, ep_req, ep_rd, ep_ack, ep_nak;
	logic [1:0]  htrans, drive_clock_select, naks;
	logic [2:0]  hsize, delay;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [8:0]  ch1_buffer_fill_count;
	logic [18:0] fl_addr;
	logic [15:0] ep_addr;
	logic [7:0]  fl_wdata, fl_rdata, ep_wdata, ep_rdata;
	logic [7:0]  ra [8] = '{OFS_FILL, OFS_SYSCFG, OFS_SCRATCH, OFS_FADDR, OFS_FDATA, OFS_EADDR,
		OFS_EDATA, 8'h60};
	logic [31:0] rw [8] = '{'1, '1, 32'h12345678, 32'h01f7ffff, '1, 32'h01ffffff, '1, '1};
	logic [31:0] re [8] = '{32'h01003f3f, 32'h00f100f3, 32'h12345678, 32'h0907ffff, 32'hff,
		32'h0900ffff, 32'hff, 32'h0};
	logic [8:0]  pf [4] = '{9'd24, 9'd20, 9'd232, 9'd236};
	int          errors, total_checks, cyc;
	assign hready = hreadyout;
	sctl_regs u_dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .ch1_buffer_fill_count, .ch1_dir_to_mem, .ch0_priority,
		.ch1_priority, .ch0_dma_req, .ch1_dma_req, .ch0_dma_grant, .ch1_dma_grant, .ch0_yield,
		.ch1_yield, .ch0_irq, .ch1_irq, .pci_irq, .drive_clock_select, .drive_clock_stop,
		.base5_decode_strap, .ch0_interface_reset, .ch1_interface_reset, .ch0_buffer_reset,
		.ch1_buffer_reset, .arbiter_reset, .bus_master_reset, .fl_req, .fl_rd, .fl_addr,
		.fl_wdata, .fl_ack, .fl_rdata, .ep_req, .ep_rd, .ep_addr, .ep_wdata, .ep_ack, .ep_nak,
		.ep_rdata);
	sctl_mem_model u_mem (.mclk, .rst, .delay, .naks, .fl_req, .fl_addr, .fl_ack, .fl_rdata,
		.ep_req, .ep_addr, .ep_ack, .ep_nak, .ep_rdata);
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic poll(input logic [7:0] a);
		do bus(1'b0, a, 32'h0); while (rd[MEM_START_BIT] !== 1'b0);
	endtask : poll
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask : step
	task automatic both(input logic v);
		@(posedge mclk);
		ch0_dma_req <= v;
		ch1_dma_req <= v;
		step(3);
	endtask : both
	task automatic summarize();
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	initial begin
		{rst, hsize, hsel, hwrite, htrans, haddr, hwdata, delay, naks} = {1'b1, 3'h2, 73'h0};
		{ch1_dir_to_mem, ch0_priority, ch0_dma_req, ch1_dma_req, ch0_irq, ch1_irq} = '0;
		base5_decode_strap = 1'b0;
		ch1_buffer_fill_count = 9'h100;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		step(6);
		chk({hresp, pci_irq, ch0_dma_grant, ch1_dma_grant, fl_req, ep_req}, 32'h0);
		bus(1'b0, OFS_FILL, 32'h0);
		chk(rd, 32'h01000000);
		bus(1'b0, OFS_SYSCFG, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, OFS_EADDR, 32'h0);
		chk(rd, 32'h08000000);
		base5_decode_strap <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, ra[i], rw[i]);
			bus(1'b0, ra[i], 32'h0);
			chk(rd, re[i]);
		end
		for (int i = 0; i < 16; i++) begin
			@(posedge mclk);
			ch0_irq <= i[0];
			ch1_irq <= i[1];
			bus(1'b1, OFS_SYSCFG, {8'h0, i[3:0], 12'h0, i[3:0], 2'h0, i[1:0]});
			step(2);
			chk(pci_irq, (i[0] & !i[2]) | (i[1] & !i[3]));
			chk({drive_clock_stop, drive_clock_select}, {&i[1:0], i[1:0]});
			chk({ch0_interface_reset, ch1_interface_reset}, i[3:2]);
			chk({ch0_buffer_reset, ch1_buffer_reset}, i[1:0]);
			chk({arbiter_reset, bus_master_reset}, i[1:0]);
		end
		bus(1'b1, OFS_SYSCFG, 32'h0);
		bus(1'b1, OFS_FILL, 32'h0505);
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			ch1_dir_to_mem <= !i[1];
			ch1_buffer_fill_count <= pf[i];
			step(3);
			chk(ch1_priority, !i[0]);
		end
		@(posedge mclk);
		ch1_dir_to_mem <= 1'b1;
		ch1_buffer_fill_count <= 9'd24;
		ch0_dma_req <= 1'b1;
		step(3);
		chk({ch0_dma_grant, ch1_dma_grant}, 2'b10);
		@(posedge mclk);
		ch1_dma_req <= 1'b1;
		step(1);
		chk({ch0_yield, ch0_dma_grant}, 2'b11);
		@(posedge mclk);
		ch0_dma_req <= 1'b0;
		step(3);
		chk({ch0_dma_grant, ch1_dma_grant}, 2'b01);
		@(posedge mclk);
		ch0_priority <= 1'b1;
		ch0_dma_req <= 1'b1;
		step(3);
		chk({ch1_yield, ch1_dma_grant}, 2'b01);
		both(1'b0);
		both(1'b1);
		chk({ch0_dma_grant, ch1_dma_grant}, 2'b01);
		both(1'b0);
		@(posedge mclk);
		ch1_buffer_fill_count <= 9'd20;
		delay <= 3'h6;
		both(1'b1);
		chk({ch0_dma_grant, ch1_dma_grant}, 2'b10);
		both(1'b0);
		bus(1'b1, OFS_FDATA, 32'ha5);
		bus(1'b1, OFS_FADDR, 32'h02001234);
		step(0);
		chk({fl_req, fl_rd, fl_wdata, fl_addr}, {2'b10, 8'ha5, 19'h01234});
		bus(1'b1, OFS_FADDR, 32'h03000077);
		step(0);
		chk({fl_req, fl_rd, fl_addr}, {2'b10, 19'h01234});
		poll(OFS_FADDR);
		bus(1'b1, OFS_FADDR, 32'h03000033);
		poll(OFS_FADDR);
		bus(1'b0, OFS_FDATA, 32'h0);
		chk(rd, 32'h69);
		@(posedge mclk);
		delay <= 3'h0;
		naks <= 2'h2;
		bus(1'b1, OFS_EADDR, 32'h03000010);
		step(0);
		chk({ep_req, ep_rd, ep_wdata, ep_addr}, {2'b11, 8'hff, 16'h0010});
		poll(OFS_EADDR);
		chk(rd, 32'h09000010);
		bus(1'b0, OFS_EDATA, 32'h0);
		chk(rd, 32'hd3);
		naks <= 2'h3;
		bus(1'b1, OFS_EADDR, 32'h03000010);
		poll(OFS_EADDR);
		chk(rd, 32'h19000010);
		bus(1'b1, OFS_EADDR, 32'h11000010);
		bus(1'b0, OFS_EADDR, 32'h0);
		chk(rd, 32'h09000010);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		step(8);
		bus(1'b0, OFS_SCRATCH, 32'h0);
		chk(rd, 32'h12345678);
		bus(1'b0, OFS_EADDR, 32'h0);
		chk(rd, 32'h18000000);
		summarize();
	end
endmodule : sctl_regs_tb
